// ===== bcm_capture.sv
// Per-source double-edge capture, delay calibration and crossing
`timescale 1ns/1ps
module bcm_capture import bcm_pkg::*; (
	// System clock side
	input  wire logic            clock,
	input  wire logic            rstn,
	input  wire logic            ce,
	// Forwarded source clock and lines
	input  wire logic            srcClk,
	input  wire logic [NCAL-1:0] lineIn,
	// Calibration
	input  wire logic            calStart,
	output logic                 calDone,
	// Captured word in system domain
	output bcm_word_s            word,
	output logic                 wordValid
);
	typedef enum logic [1:0] {CAL_IDLE, CAL_SWEEP, CAL_DONE} bcm_cal_e;
	typedef struct packed {
		logic [NCAL-1:0][HISTW-1:0] hist;
		logic [NCAL-1:0][TAPW-1:0]  tap;
		logic [NCAL-1:0][TAPW-1:0]  bestTap;
		logic [NCAL-1:0][ERRW-1:0]  errCnt;
		logic [NCAL-1:0][ERRW-1:0]  bestErr;
		logic [TAPW-1:0]            sweep;
		logic [5:0]                 sampleCnt;
		bcm_cal_e                   cal;
		logic                       calOk;
		logic                       calS1;
		logic                       calS2;
		bcm_word_s                  hold;
		logic                       req;
		logic                       ackS1;
		logic                       ackS2;
	} bcm_lnk_s;
	typedef struct packed {
		logic      reqS1;
		logic      reqS2;
		logic      ack;
		bcm_word_s word;
		logic      valid;
		logic      doneS1;
		logic      doneS2;
	} bcm_sys_s;

	bcm_lnk_s        l, next_l;
	bcm_sys_s        s, next_s;
	logic [NCAL-1:0] fallSmp;
	logic [NCAL-1:0] aligned0, aligned1;

	// ****************************************
	// Falling edge samples
	// ****************************************
	always_ff @(negedge srcClk or negedge rstn) begin
		if (!rstn) begin
			fallSmp <= '0;
		end else begin
			fallSmp <= lineIn;
		end
	end

	// ****************************************
	// Link domain
	// ****************************************
	always_comb begin
		next_l = l;
		next_l.calS1 = calStart;
		next_l.calS2 = l.calS1;
		next_l.ackS1 = s.ack;
		next_l.ackS2 = l.ackS1;
		for (int i = 0; i < NCAL; i++) begin
			next_l.hist[i] = {l.hist[i][HISTW-3:0], fallSmp[i], lineIn[i]};
			aligned0[i] = l.hist[i][l.tap[i] + TAPW'(1)];
			aligned1[i] = l.hist[i][l.tap[i]];
		end
		unique case (l.cal)
			CAL_IDLE: begin
				if (l.calS2) begin
					next_l.cal = CAL_SWEEP;
					next_l.sweep = '0;
					next_l.sampleCnt = '0;
					next_l.errCnt = '0;
					next_l.bestErr = '1;
					next_l.calOk = 1'b0;
				end
			end
			CAL_SWEEP: begin
				// Training pattern toggles every bit; equal neighbours are errors
				for (int i = 0; i < NCAL; i++) begin
					if (l.hist[i][l.sweep + TAPW'(1)] == l.hist[i][l.sweep]) begin
						next_l.errCnt[i] = l.errCnt[i] + ERRW'(1);
					end
				end
				next_l.sampleCnt = l.sampleCnt + 6'h1;
				if (l.sampleCnt == 6'(CAL_SAMPLES - 1)) begin
					for (int i = 0; i < NCAL; i++) begin
						if (l.errCnt[i] < l.bestErr[i]) begin
							next_l.bestErr[i] = l.errCnt[i];
							next_l.bestTap[i] = l.sweep;
						end
					end
					next_l.errCnt = '0;
					next_l.sweep = l.sweep + TAPW'(1);
					if (l.sweep == TAPW'(NTAP - 1)) begin
						next_l.cal = CAL_DONE;
					end
				end
			end
			CAL_DONE: begin
				next_l.tap = l.bestTap;
				next_l.calOk = 1'b1;
				if (!l.calS2) begin
					next_l.cal = CAL_IDLE;
				end
			end
		endcase
		// New word only once the previous one is acknowledged
		if (l.req == l.ackS2) begin
			next_l.hold = {aligned0[NDATA-1:0], aligned0[NPAR_LINE],
				aligned1[NDATA-1:0], aligned1[NPAR_LINE]};
			next_l.req = ~l.req;
		end
	end

	always_ff @(posedge srcClk or negedge rstn) begin
		if (!rstn) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// ****************************************
	// System domain
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.reqS1 = l.req;
		next_s.reqS2 = s.reqS1;
		next_s.doneS1 = l.calOk;
		next_s.doneS2 = s.doneS1;
		next_s.valid = 1'b0;
		if (s.reqS2 != s.ack) begin
			next_s.word = l.hold;
			next_s.ack = s.reqS2;
			next_s.valid = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign word      = s.word;
	assign wordValid = s.valid;
	assign calDone   = s.doneS2;

	// ****************************************
	// Checks
	// ****************************************
	property p_calKeep;
		@(posedge srcClk) disable iff (!rstn)
		(l.cal == CAL_IDLE && !l.calS2) |=> $stable(l.tap);
	endproperty
	a_calKeep: assert property (p_calKeep) else $error("Delay taps changed outside calibration");

	property p_calLength;
		@(posedge srcClk) disable iff (!rstn)
		(l.cal == CAL_IDLE && l.calS2) |=> (l.cal == CAL_SWEEP) [*8];
	endproperty
	a_calLength: assert property (p_calLength) else $error("Calibration sweep ended too soon");
endmodule

// ===== bcm_merge_path.sv
// Top of the backplane capture, count, merge and output path
//
// Operation
// - Crate role counts local objects from 400 inputs, sends counts on cables.
// - Every role serializes local information onto two twelve-fibre optical ribbons.
// - System role keeps local counts, merges them with two or three cables.
// - System role drives final result to the central trigger processor cables.
// - Optical output may use a subset of fibres, six planned per ribbon.
// - Topological device results may drive the central trigger processor cables.
// - Topological output allowed only in crate role, avoiding output contention.
// - Each source has 25 lines at 160 Mbps, 6.25 ns per bit.
// - Per source: 23 data lines, one parity, one 80 MHz forwarded clock.
// - Data and parity sampled on rising and falling forwarded clock edges.
// - Each line has its own programmable input delay for skew; only the 24 data and parity lines get a tap, set by calibration.
// - Calibration finds and keeps best delay for all 24 lines per source.
// - Combined clock and parity line mode remains supported.
// - Combined mode needs one clock manager per source, 16 of 18.
// - Units form four groups, each handling one object type.
`timescale 1ns/1ps
module bcm_merge_path import bcm_pkg::*; (
	// Clock, reset, enable
	input  wire logic                              clock,
	input  wire logic                              rstn,
	input  wire logic                              ce,
	// Backplane sources
	input  wire logic [NSRC-1:0]                   srcClk,
	input  wire logic [NSRC-1:0][NCAL-1:0]         bpLine,
	// Calibration
	input  wire logic                              calStart,
	output logic      [NSRC-1:0]                   calDone,
	// Static configuration
	input  wire bcm_cfg_s                          cfg,
	// Parity flags
	input  wire logic [NSRC-1:0]                   parityClear,
	output logic      [NSRC-1:0]                   parityErr,
	// Cable links, two-way
	input  wire logic [NCABLE-1:0][CABW-1:0]       cableIn,
	output logic      [NCABLE-1:0][CABW-1:0]       cableOut,
	output logic      [NCABLE-1:0]                 cableOeN,
	// Topological device results
	input  wire logic [NCTP-1:0][CTPW-1:0]         topoResult,
	// Trigger processor cables, output only with enables
	output logic      [NCTP-1:0][CTPW-1:0]         ctpOut,
	output logic      [NCTP-1:0]                   ctpOeN,
	// Optical fibres
	output logic      [NRIBBON*NFIBRE-1:0]         optTx
);
	typedef struct packed {
		bcm_word_s [NSRC-1:0]                lat;
		logic [NSRC-1:0]                     parityErr;
		logic [CNTW-1:0]                     localCount;
		logic [NCABLE-1:0][CABW-1:0]         cableS1;
		logic [NCABLE-1:0][CABW-1:0]         cableS2;
		logic [NCTP-1:0][CTPW-1:0]           topoS1;
		logic [NCTP-1:0][CTPW-1:0]           topoS2;
		logic [NCABLE-1:0][CABW-1:0]         cableOut;
		logic [NCABLE-1:0]                   cableOeN;
		logic [NCTP-1:0][CTPW-1:0]           ctpOut;
		logic [NCTP-1:0]                     ctpOeN;
		logic [NFIBRE-1:0][CNTW-1:0]         optShift;
		logic [NRIBBON*NFIBRE-1:0]           optTx;
		logic [3:0]                          frameCnt;
		logic                                clkTog;
	} bcm_state_s;

	bcm_state_s            s, next_s;
	bcm_word_s [NSRC-1:0]  word;
	logic [NSRC-1:0]       wordValid;
	logic [NSRC-1:0]       parNew;
	logic [CNTW-1:0]       localSum;
	logic [CNTW-1:0]       mergeSum;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic [5:0] popc(input bcm_word_s w, input logic comb);
		logic [5:0] n;
		n = '0;
		for (int b = 0; b < NDATA; b++) begin
			n = n + 6'(w.data0[b]) + 6'(w.data1[b]);
		end
		if (comb) begin
			n = n + 6'(w.par0) + 6'(w.par1);
		end
		return n;
	endfunction

	function automatic logic parBad(input bcm_word_s w);
		return ((^w.data0) != w.par0) || ((^w.data1) != w.par1);
	endfunction

	// ****************************************
	// Per-source capture
	// ****************************************
	for (genvar g = 0; g < NSRC; g++) begin : gSrc
		bcm_capture uCap (
			.clock     (clock),
			.rstn      (rstn),
			.ce        (ce),
			.srcClk    (srcClk[g]),
			.lineIn    (bpLine[g]),
			.calStart  (calStart),
			.calDone   (calDone[g]),
			.word      (word[g]),
			.wordValid (wordValid[g])
		);
	end

	// ****************************************
	// Count, merge and drive
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.cableS1 = cableIn;
		next_s.cableS2 = s.cableS1;
		next_s.topoS1 = topoResult;
		next_s.topoS2 = s.topoS1;
		parNew = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (wordValid[i]) begin
				next_s.lat[i] = word[i];
				// In combined mode the parity line is not a separate check
				parNew[i] = !cfg.combinedClk && parBad(word[i]);
			end
		end
		next_s.parityErr = (s.parityErr & ~parityClear) | parNew;
		localSum = '0;
		for (int i = 0; i < NSRC; i++) begin
			localSum = localSum + CNTW'(popc(s.lat[i], cfg.combinedClk));
		end
		next_s.localCount = localSum;
		mergeSum = s.localCount;
		for (int c = 0; c < NCABLE; c++) begin
			if (2'(c) < cfg.cableCount) begin
				mergeSum = mergeSum + s.cableS2[c][CNTW-1:0];
			end
		end
		next_s.clkTog = ~s.clkTog;
		next_s.cableOeN = '1;
		next_s.cableOut = '0;
		next_s.ctpOeN = '1;
		next_s.ctpOut = '0;
		if (cfg.role == ROLE_CRATE) begin
			for (int c = 0; c < NCABLE; c++) begin
				if (2'(c) < cfg.cableCount) begin
					next_s.cableOut[c] = {1'b0, ~s.clkTog, 9'h0, s.localCount};
					next_s.cableOut[c][CAB_PAR_BIT] = ^next_s.cableOut[c];
					next_s.cableOeN[c] = 1'b0;
				end
			end
			if (cfg.topoEnable) begin
				for (int c = 0; c < NCTP; c++) begin
					if (2'(c) < cfg.ctpCount) begin
						next_s.ctpOut[c] = s.topoS2[c];
						next_s.ctpOeN[c] = 1'b0;
					end
				end
			end
		end else begin
			for (int c = 0; c < NCTP; c++) begin
				if (2'(c) < cfg.ctpCount) begin
					next_s.ctpOut[c] = {2'b0, 13'h0, cfg.obj, mergeSum};
					next_s.ctpOut[c][CTP_CLK_BIT] = ~s.clkTog;
					next_s.ctpOut[c][CTP_PAR_BIT] = ^next_s.ctpOut[c];
					next_s.ctpOeN[c] = 1'b0;
				end
			end
		end
		// Optical serializer, one bit per fibre per cycle
		next_s.frameCnt = s.frameCnt + 4'h1;
		for (int f = 0; f < NFIBRE; f++) begin
			if (s.frameCnt == 4'(FRAME_LAST)) begin
				next_s.optShift[f] = s.localCount;
			end else begin
				next_s.optShift[f] = {s.optShift[f][CNTW-2:0], 1'b0};
			end
			for (int r = 0; r < NRIBBON; r++) begin
				next_s.optTx[r*NFIBRE+f] = cfg.fibreMask[f] & s.optShift[f][CNTW-1];
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.cableOeN <= '1;
			s.ctpOeN <= '1;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign parityErr = s.parityErr;
	assign cableOut  = s.cableOut;
	assign cableOeN  = s.cableOeN;
	assign ctpOut    = s.ctpOut;
	assign ctpOeN    = s.ctpOeN;
	assign optTx     = s.optTx;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cbSys @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_crateStep;
		ce && cfg.role == ROLE_CRATE && cfg.cableCount != 2'h0;
	endsequence

	property p_crateCable;
		s_crateStep ##0 $stable(cfg) |=> !s.cableOeN[0] && s.cableOut[0][CNTW-1:0] == $past(s.localCount);
	endproperty
	a_crateCable: assert property (p_crateCable) else $error("Crate count not sent on cable");

	property p_systemCtp;
		ce && cfg.role == ROLE_SYSTEM && cfg.ctpCount != 2'h0
			|=> !s.ctpOeN[0] && s.ctpOut[0][CNTW-1:0] == $past(mergeSum)
			&& s.cableOeN == '1;
	endproperty
	a_systemCtp: assert property (p_systemCtp) else $error("Merged result not on trigger cable");

	property p_objType;
		ce && cfg.role == ROLE_SYSTEM && cfg.ctpCount != 2'h0
			|=> s.ctpOut[0][CTP_OBJ_LSB+1:CTP_OBJ_LSB] == $past(cfg.obj);
	endproperty
	a_objType: assert property (p_objType) else $error("Object type missing on trigger cable");

	property p_noContention;
		ce && cfg.role == ROLE_CRATE && !cfg.topoEnable |=> s.ctpOeN == '1;
	endproperty
	a_noContention: assert property (p_noContention) else $error("Crate drives trigger cable");

	property p_parSet;
		ce && parNew != '0 |=> (s.parityErr & $past(parNew)) == $past(parNew);
	endproperty
	a_parSet: assert property (p_parSet) else $error("Parity error not flagged");

	property p_parSticky;
		ce && parityClear == '0 |=> (s.parityErr & $past(s.parityErr)) == $past(s.parityErr);
	endproperty
	a_parSticky: assert property (p_parSticky) else $error("Parity flag dropped without clear");

	property p_fibreMask;
		(s.optTx[NFIBRE-1:0] & ~$past(cfg.fibreMask)) == '0 || !$past(ce);
	endproperty
	a_fibreMask: assert property (p_fibreMask) else $error("Masked fibre transmitting");

	sequence s_frameEnd;
		ce && s.frameCnt == 4'(FRAME_LAST);
	endsequence

	property p_frame;
		s_frameEnd |=> s.frameCnt == 4'h0 && s.optShift[0] == $past(s.localCount);
	endproperty
	a_frame: assert property (p_frame) else $error("Optical frame not reloaded");

	property p_cableClock;
		ce ##1 ce && s.cableOeN[0] == 1'b0 ##1 s.cableOeN[0] == 1'b0
			|-> s.cableOut[0][CAB_CLK_BIT] != $past(s.cableOut[0][CAB_CLK_BIT]);
	endproperty
	a_cableClock: assert property (p_cableClock) else $error("Cable clock bit not toggling");

	sequence s_systemStep;
		ce && cfg.role == ROLE_SYSTEM && cfg.ctpCount != 2'h0;
	endsequence

	property p_cableParity;
		s_crateStep
			|=> s.cableOut[0][CAB_PAR_BIT] == ^s.cableOut[0][CAB_PAR_BIT-1:0];
	endproperty
	a_cableParity: assert property (p_cableParity) else $error("Cable parity bit wrong");

	property p_cableSpare;
		s_crateStep
			|=> s.cableOut[0][CAB_CLK_BIT-1:CNTW] == '0;
	endproperty
	a_cableSpare: assert property (p_cableSpare) else $error("Cable spare bits set");

	property p_cableLimit;
		ce && cfg.role == ROLE_CRATE && cfg.cableCount == 2'h1
			|=> s.cableOeN[NCABLE-1:1] == '1;
	endproperty
	a_cableLimit: assert property (p_cableLimit) else $error("Unused cable driven");

	property p_ctpParity;
		s_systemStep
			|=> s.ctpOut[0][CTP_PAR_BIT] == ^s.ctpOut[0][CTP_PAR_BIT-1:0];
	endproperty
	a_ctpParity: assert property (p_ctpParity) else $error("Trigger parity bit wrong");

	property p_ctpSpare;
		s_systemStep
			|=> s.ctpOut[0][CTP_CLK_BIT-1:CTP_OBJ_LSB+2] == '0;
	endproperty
	a_ctpSpare: assert property (p_ctpSpare) else $error("Trigger spare bits set");

	property p_ctpClock;
		s_systemStep ##1 s_systemStep
			|=> s.ctpOut[0][CTP_CLK_BIT] != $past(s.ctpOut[0][CTP_CLK_BIT]);
	endproperty
	a_ctpClock: assert property (p_ctpClock) else $error("Trigger clock bit stuck");

	property p_ctpLimit;
		ce && cfg.role == ROLE_SYSTEM && cfg.ctpCount == 2'h1
			|=> s.ctpOeN[1];
	endproperty
	a_ctpLimit: assert property (p_ctpLimit) else $error("Unused trigger cable driven");

	property p_systemQuiet;
		ce && cfg.role == ROLE_SYSTEM |=> s.cableOeN == '1;
	endproperty
	a_systemQuiet: assert property (p_systemQuiet) else $error("System drives a cable");

	property p_topoPass;
		ce && cfg.role == ROLE_CRATE && cfg.topoEnable && cfg.ctpCount != 2'h0
			|=> !s.ctpOeN[0] && s.ctpOut[0] == $past(s.topoS2[0]);
	endproperty
	a_topoPass: assert property (p_topoPass) else $error("Topological result not passed");

	property p_mergeTwo;
		s_systemStep ##0 cfg.cableCount == 2'h2
			|=> s.ctpOut[0][CNTW-1:0]
			== $past(s.localCount + s.cableS2[0][CNTW-1:0] + s.cableS2[1][CNTW-1:0]);
	endproperty
	a_mergeTwo: assert property (p_mergeTwo) else $error("Two cable merge wrong");

	property p_parClear;
		ce && parNew == '0 && parityClear != '0
			|=> (s.parityErr & $past(parityClear)) == '0;
	endproperty
	a_parClear: assert property (p_parClear) else $error("Parity flag not cleared");

	property p_ribbonCopy;
		s.optTx[2*NFIBRE-1:NFIBRE] == s.optTx[NFIBRE-1:0];
	endproperty
	a_ribbonCopy: assert property (p_ribbonCopy) else $error("Ribbons differ");

	property p_shift;
		ce && s.frameCnt != 4'(FRAME_LAST)
			|=> s.optShift[0] == {$past(s.optShift[0][CNTW-2:0]), 1'b0};
	endproperty
	a_shift: assert property (p_shift) else $error("Optical shift wrong");
endmodule

// ===== bcm_merge_path_test.sv
// Self-checking bench of the capture, count and merge path
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t mismatch got %h want %h", $time, (a), (b)); end end
module bcm_merge_path_test import bcm_pkg::*; ;
	logic                         clock, rstn, ce, train, calStart, hit;
	logic [NSRC-1:0]              srcClk, calDone, parityClear, parityErr, badPar, m;
	logic [NSRC-1:0][NCAL-1:0]    bpLine;
	logic [NSRC-1:0][NDATA-1:0]   dataIn;
	bcm_cfg_s                     cfg;
	logic [NCABLE-1:0][CABW-1:0]  cableIn, cableOut;
	logic [NCABLE-1:0]            cableOeN;
	logic [NCTP-1:0][CTPW-1:0]    topoResult, ctpOut;
	logic [NCTP-1:0]              ctpOeN;
	logic [NRIBBON*NFIBRE-1:0]    optTx;
	logic [15:0]                  sh;
	int                           num_errors, n_compared, cyc, ex, s;
	bcm_src_model i_src (.train(train), .dataIn(dataIn), .badPar(badPar),
		.srcClk(srcClk), .bpLine(bpLine));
	bcm_merge_path i_dut (.clock(clock), .rstn(rstn), .ce(ce), .srcClk(srcClk),
		.bpLine(bpLine), .calStart(calStart), .calDone(calDone), .cfg(cfg),
		.parityClear(parityClear), .parityErr(parityErr), .cableIn(cableIn),
		.cableOut(cableOut), .cableOeN(cableOeN), .topoResult(topoResult),
		.ctpOut(ctpOut), .ctpOeN(ctpOeN), .optTx(optTx));
	// ****************************************
	// Clock and timeout
	// ****************************************
	initial clock = 1'b0;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	// ****************************************
	// Model and helpers
	// ****************************************
	function automatic int expCount(input logic comb);
		int n;
		n = 0;
		for (int i = 0; i < NSRC; i++) begin
			n += 2 * $countones(dataIn[i]);
			if (comb) n += 2 * (^dataIn[i] ^ badPar[i]);
		end
		return n;
	endfunction
	task automatic setCfg(input bcm_role_e r, input bcm_obj_e o, input logic comb,
		input logic topo, input int cab, input int central_trigger_processor);
		@(negedge clock);
		cfg.role = r;
		cfg.obj = o;
		cfg.combinedClk = comb;
		cfg.topoEnable = topo;
		cfg.cableCount = 2'(cab);
		cfg.ctpCount = 2'(central_trigger_processor);
		repeat (40) @(negedge clock);
	endtask
	task close_out;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rstn = 1'b0; ce = 1'b1; train = 1'b0; calStart = 1'b0; parityClear = '0;
		badPar = '0; dataIn = '0; cableIn = '0; topoResult = '0; cfg = '0;
		cfg.fibreMask = FIBRE_MASK_RST;
		num_errors = 0; n_compared = 0; cyc = 0;
		void'($urandom(78485));
		repeat (8) @(negedge clock);
		`CHK({cableOeN, ctpOeN}, 5'h1f)
		`CHK({optTx, parityErr, calDone, cableOut, ctpOut}, '0)
		rstn = 1'b1;
		// Calibration on training pattern
		train = 1'b1;
		calStart = 1'b1;
		for (int i = 0; i < 5000 && calDone !== '1; i++) @(negedge clock);
		`CHK(calDone, 16'hffff)
		calStart = 1'b0;
		train = 1'b0;
		for (int i = 0; i < NSRC; i++) dataIn[i] = NDATA'($urandom());
		for (int c = 0; c < NCABLE; c++) cableIn[c] = CABW'($urandom() & 32'hfff);
		for (int c = 0; c < NCTP; c++) topoResult[c] = {1'b0, $urandom()};
		repeat (40) @(negedge clock);
		`CHK(calDone, 16'hffff)
		$display("test calibration done");
		// Crate role, cable counts 0 to 2
		for (int k = 0; k < 3; k++) begin
			setCfg(ROLE_CRATE, OBJ_JET, 1'b0, 1'b0, k, 0);
			ex = expCount(1'b0);
			`CHK(ctpOeN, 2'h3)
			for (int c = 0; c < NCABLE; c++) begin
				`CHK(cableOeN[c], (c < k) ? 1'b0 : 1'b1)
				if (c < k) begin
					`CHK(cableOut[c][15:0], ex[15:0])
					`CHK(cableOut[c][24:16], 9'h000)
					`CHK(cableOut[c][26], ^cableOut[c][25:0])
				end
			end
		end
		$display("test crate done");
		// Crate role with topological results
		for (int k = 1; k < 3; k++) begin
			setCfg(ROLE_CRATE, OBJ_TAU, 1'b0, 1'b1, 1, k);
			for (int c = 0; c < NCTP; c++) begin
				`CHK(ctpOeN[c], (c < k) ? 1'b0 : 1'b1)
				if (c < k) `CHK(ctpOut[c], topoResult[c])
			end
		end
		$display("test topo done");
		// System role, every object type
		for (int j = 0; j < 4; j++) begin
			setCfg(ROLE_SYSTEM, bcm_obj_e'(j), 1'b0, 1'b0, 2 + j % 2, 1 + j / 2);
			ex = expCount(1'b0);
			for (int c = 0; c < 2 + j % 2; c++) ex += cableIn[c][15:0];
			`CHK(cableOeN, 3'h7)
			for (int c = 0; c < NCTP; c++) begin
				`CHK(ctpOeN[c], (c < 1 + j / 2) ? 1'b0 : 1'b1)
				if (c < 1 + j / 2) begin
					`CHK(ctpOut[c][15:0], ex[15:0])
					`CHK(ctpOut[c][17:16], 2'(j))
					`CHK(ctpOut[c][30:18], 13'h0000)
					`CHK(ctpOut[c][32], ^ctpOut[c][31:0])
				end
			end
		end
		$display("test system done");
		// Parity flag set, hold and clear
		setCfg(ROLE_CRATE, OBJ_ELECTRON, 1'b0, 1'b0, 1, 0);
		parityClear = '1;
		@(negedge clock);
		parityClear = '0;
		repeat (4) @(negedge clock);
		`CHK(parityErr, 16'h0000)
		s = $urandom() % NSRC;
		m = '0;
		m[s] = 1'b1;
		badPar[s] = 1'b1;
		repeat (30) @(negedge clock);
		badPar = '0;
		repeat (30) @(negedge clock);
		`CHK(parityErr, m)
		parityClear = m;
		@(negedge clock);
		parityClear = '0;
		repeat (2) @(negedge clock);
		`CHK(parityErr, 16'h0000)
		// Combined clock and parity mode
		setCfg(ROLE_CRATE, OBJ_ENERGY, 1'b1, 1'b0, 1, 0);
		badPar[s] = 1'b1;
		repeat (40) @(negedge clock);
		ex = expCount(1'b1);
		`CHK(parityErr, 16'h0000)
		`CHK(cableOut[0][15:0], ex[15:0])
		$display("test parity done");
		// Optical serial output with random fibre mask
		cfg.fibreMask = NFIBRE'($urandom()) | 12'h001;
		repeat (20) @(negedge clock);
		hit = 1'b0;
		sh = '0;
		for (int i = 0; i < 48; i++) begin
			sh = {sh[14:0], optTx[0]};
			`CHK(optTx[23:12], optTx[11:0])
			`CHK(optTx[11:0] & ~cfg.fibreMask, 12'h000)
			if (i >= 16 && sh === ex[15:0]) hit = 1'b1;
			@(negedge clock);
		end
		`CHK(hit, 1'b1)
		$display("test optical done");
		close_out();
	end
endmodule

// ===== bcm_pkg.sv
// Shared constants and types of the backplane capture and merge path
package bcm_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NSRC            = 16;
	localparam int NLINE           = 25;
	localparam int NDATA           = 23;
	localparam int NCAL            = 24;
	localparam int NPAR_LINE       = 23;
	localparam int NTAP            = 7;
	localparam int TAPW            = 3;
	localparam int HISTW           = 8;
	localparam int ERRW            = 7;
	localparam int CNTW            = 16;
	localparam int NCABLE          = 3;
	localparam int CABW            = 27;
	localparam int NCTP            = 2;
	localparam int CTPW            = 33;
	localparam int NFIBRE          = 12;
	localparam int NRIBBON         = 2;
	localparam int PLAN_FIBRES     = 6;
	localparam int CLK_MGR_TOTAL   = 18;
	localparam int CLK_MGR_PER_SRC = 1;
	localparam int CLK_MGR_FREE    = CLK_MGR_TOTAL - NSRC * CLK_MGR_PER_SRC;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CAB_CLK_BIT = 25;
	localparam int CAB_PAR_BIT = 26;
	localparam int CTP_OBJ_LSB = 16;
	localparam int CTP_CLK_BIT = 31;
	localparam int CTP_PAR_BIT = 32;
	// ****************************************
	// Timing
	// ****************************************
	localparam int  LINE_RATE_MBPS = 160;
	localparam int  FWD_CLK_MHZ    = 80;
	localparam real BIT_NS         = 6.25;
	localparam int  CAL_SAMPLES    = 64;
	localparam int  FRAME_LAST     = 15;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [NFIBRE-1:0] FIBRE_MASK_RST = 12'h03f;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {ROLE_CRATE, ROLE_SYSTEM} bcm_role_e;
	typedef enum logic [1:0] {OBJ_ELECTRON, OBJ_TAU, OBJ_JET, OBJ_ENERGY} bcm_obj_e;
	typedef struct packed {
		logic [NDATA-1:0] data0;
		logic             par0;
		logic [NDATA-1:0] data1;
		logic             par1;
	} bcm_word_s;
	typedef struct packed {
		bcm_role_e         role;
		bcm_obj_e          obj;
		logic              combinedClk;
		logic              topoEnable;
		logic [1:0]        cableCount;
		logic [1:0]        ctpCount;
		logic [NFIBRE-1:0] fibreMask;
	} bcm_cfg_s;
endpackage

// ===== bcm_src_model.sv
// Sixteen backplane source modules with forwarded clocks
`timescale 1ns/1ps
module bcm_src_model import bcm_pkg::*; (
	// Control from the bench
	input  wire logic                       train,
	input  wire logic [NSRC-1:0][NDATA-1:0] dataIn,
	input  wire logic [NSRC-1:0]            badPar,
	// Backplane lines
	output logic      [NSRC-1:0]            srcClk,
	output logic      [NSRC-1:0][NCAL-1:0]  bpLine
);
	logic tog;
	// ****************************************
	// Forwarded clock, free running
	// ****************************************
	initial begin
		srcClk = '0;
		bpLine = '0;
		tog = 1'b0;
		#1.7;
		forever #3 srcClk = ~srcClk;
	end
	// ****************************************
	// Launch mid bit, data then parity line
	// ****************************************
	always @(srcClk[0]) begin
		#1.5;
		tog = ~tog;
		for (int s = 0; s < NSRC; s++) begin
			bpLine[s] = train ? {NCAL{tog}} : {^dataIn[s] ^ badPar[s], dataIn[s]};
		end
	end
endmodule
